// *** hdl/fpa_pkg.sv ***
package fpa_pkg;
	// -------------------------------------------------------------
	// widths and field layout
	// -------------------------------------------------------------
	localparam int FPA_W       = 40;
	localparam int FPA_NREG    = 8;
	localparam int FPA_LO_LSB  = 0;
	localparam int FPA_HI_LSB  = 16;
	localparam int FPA_EX_LSB  = 32;
	localparam logic [39:0] FPA_REG_RST = 40'h00_0000_0000;
	localparam int FPA_PIPE    = 3;

	// -------------------------------------------------------------
	// operation encodings
	// -------------------------------------------------------------
	typedef enum logic [3:0] {
		FPA_OP_NOP, FPA_OP_MAC, FPA_OP_ADD, FPA_OP_SUB, FPA_OP_AND,
		FPA_OP_OR, FPA_OP_XOR, FPA_OP_NOT, FPA_OP_NEG, FPA_OP_PASS,
		FPA_OP_SHL, FPA_OP_SHRA, FPA_OP_SHRL, FPA_OP_LOAD
	} fpa_op_t;

	typedef enum logic [1:0] {FPA_PSH_NONE, FPA_PSH_1, FPA_PSH_16} fpa_psh_t;

	// field mask: bit0 low, bit1 high, bit2 extension
	typedef struct packed {
		fpa_op_t     op;
		logic [2:0]  src_a;
		logic [2:0]  src_b;
		logic [2:0]  dst;
		logic [2:0]  fmask;
		logic        mac_sub;
		fpa_psh_t    psh;
		logic [5:0]  shamt;
		logic [39:0] load_data;
	} fpa_cmd_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  dst;
		logic [2:0]  fmask;
		logic [39:0] value;
	} fpa_wb_t;
endpackage

// *** hdl/fpa_shifter.sv ***
`timescale 1ns/1ps
module fpa_shifter
(
	// operand and control
	input  wire logic [39:0] din,
	input  wire logic [5:0]  shamt,
	input  wire logic        dir_right,
	input  wire logic        arith,
	// result
	output logic      [39:0] dout
);
	import fpa_pkg::*;

	// counts of 40 and above saturate to all fill
	always_comb
	begin
		if (!dir_right)
			dout = (shamt >= 6'h28) ? 40'h00_0000_0000 : (din << shamt);
		else if (arith)
			dout = (shamt >= 6'h28) ? {40{din[39]}} : 40'($signed(din) >>> shamt);
		else
			dout = (shamt >= 6'h28) ? 40'h00_0000_0000 : (din >> shamt);
	end
endmodule

// *** hdl/fpa_unit.sv ***
`timescale 1ns/1ps
module fpa_unit
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	// issued operation
	input  wire logic              cmd_valid,
	input  wire fpa_pkg::fpa_cmd_t cmd,
	// store read port
	input  wire logic [2:0]        rd_sel,
	output logic      [39:0]       rd_data,
	// completion
	output logic                   wb_valid,
	output logic      [39:0]       wb_value
);
	import fpa_pkg::*;

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic [39:0] fmask_bits(input logic [2:0] m);
		fmask_bits = {{8{m[2]}}, {16{m[1]}}, {16{m[0]}}};
	endfunction

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	logic [39:0] gr_ff [FPA_NREG];
	logic [39:0] nxt_gr [FPA_NREG];
	fpa_cmd_t    s1_ff, nxt_s1;
	logic        s1v_ff, nxt_s1v;
	logic [39:0] a_ff, b_ff, nxt_a, nxt_b;
	fpa_wb_t     s2_ff, nxt_s2;
	logic [39:0] rd_ff, nxt_rd;
	logic [39:0] res;
	logic [39:0] sh_out;
	logic [39:0] acc;
	logic [31:0] prod;

	// stage 2 shifter operates on operand a
	fpa_shifter u_sh
	(
		.din       (a_ff),
		.shamt     (s1_ff.shamt),
		.dir_right (s1_ff.op != FPA_OP_SHL),
		.arith     (s1_ff.op == FPA_OP_SHRA),
		.dout      (sh_out)
	);

	// -------------------------------------------------------------
	// stage 1: decode and operand read, no bypass of results
	// -------------------------------------------------------------
	always_comb
	begin
		nxt_s1v = cmd_valid;
		nxt_s1  = cmd;
		nxt_a   = gr_ff[cmd.src_a];
		nxt_b   = gr_ff[cmd.src_b];
		nxt_rd  = gr_ff[rd_sel];
	end

	// -------------------------------------------------------------
	// stage 2: execute
	// -------------------------------------------------------------
	always_comb
	begin
		// keep the full 32-bit product; widening it later keeps the sign intact
		prod = 32'($signed(b_ff[15:0]) * $signed(b_ff[31:16]));
		case (s1_ff.psh)
			FPA_PSH_1:  acc = 40'($signed(a_ff) >>> 1);
			FPA_PSH_16: acc = 40'($signed(a_ff) >>> 16);
			default:    acc = a_ff;
		endcase
		case (s1_ff.op)
			FPA_OP_MAC:  res = s1_ff.mac_sub ? acc - {{8{prod[31]}}, prod}
			                                 : acc + {{8{prod[31]}}, prod};
			FPA_OP_ADD:  res = a_ff + b_ff;
			FPA_OP_SUB:  res = a_ff - b_ff;
			FPA_OP_AND:  res = a_ff & b_ff;
			FPA_OP_OR:   res = a_ff | b_ff;
			FPA_OP_XOR:  res = a_ff ^ b_ff;
			FPA_OP_NOT:  res = ~a_ff;
			FPA_OP_NEG:  res = 40'h00_0000_0000 - a_ff;
			FPA_OP_PASS: res = a_ff;
			FPA_OP_SHL, FPA_OP_SHRA, FPA_OP_SHRL: res = sh_out;
			FPA_OP_LOAD: res = s1_ff.load_data;
			default:     res = 40'h00_0000_0000;
		endcase
		nxt_s2.valid = s1v_ff && (s1_ff.op != FPA_OP_NOP);
		nxt_s2.dst   = s1_ff.dst;
		nxt_s2.fmask = s1_ff.fmask;
		nxt_s2.value = res;
	end

	// -------------------------------------------------------------
	// stage 3: write back under field mask
	// -------------------------------------------------------------
	// a source read in the cycle of the write still sees the old value
	always_comb
	begin
		for (int i = 0; i < FPA_NREG; i++)
		begin
			nxt_gr[i] = gr_ff[i];
			if (s2_ff.valid && s2_ff.dst == 3'(i))
				nxt_gr[i] = (gr_ff[i] & ~fmask_bits(s2_ff.fmask))
				          | (s2_ff.value & fmask_bits(s2_ff.fmask));
		end
	end

	// no forwarding: a result reaches sources three cycles after issue
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < FPA_NREG; i++)
				gr_ff[i] <= FPA_REG_RST;
			s1_ff  <= '0;
			s1v_ff <= 1'b0;
			a_ff   <= '0;
			b_ff   <= '0;
			s2_ff  <= '0;
			rd_ff  <= '0;
		end
		else
		begin
			for (int i = 0; i < FPA_NREG; i++)
				gr_ff[i] <= nxt_gr[i];
			s1_ff  <= nxt_s1;
			s1v_ff <= nxt_s1v;
			a_ff   <= nxt_a;
			b_ff   <= nxt_b;
			s2_ff  <= nxt_s2;
			rd_ff  <= nxt_rd;
		end
	end

	assign rd_data  = rd_ff;
	assign wb_valid = s2_ff.valid;
	assign wb_value = s2_ff.value;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	a_wb_latency: assert property (@(posedge sys_clk) disable iff (!rstn)
		cmd_valid && cmd.op == FPA_OP_ADD |-> ##2 wb_valid)
		else $error("add did not complete in two cycles");
	a_field_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
		s2_ff.valid && !s2_ff.fmask[2] |=> gr_ff[$past(s2_ff.dst)][39:32] ==
		$past(gr_ff[s2_ff.dst][39:32]))
		else $error("extension field changed on partial write");
	a_shrl_fill: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_SHRL && s1_ff.shamt != 6'h00 |=> !s2_ff.value[39])
		else $error("logical right shift kept sign");
	a_shra_fill: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_SHRA |=> s2_ff.value[39] == $past(a_ff[39]))
		else $error("arithmetic right shift lost sign");
	a_psh_16: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_MAC && s1_ff.psh == FPA_PSH_16 && b_ff[15:0] == 16'h0000
		|=> s2_ff.value == 40'($signed($past(a_ff)) >>> 16))
		else $error("pre-shift by 16 wrong");
	a_mac_sub: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_MAC && s1_ff.psh == FPA_PSH_NONE && s1_ff.mac_sub
		&& b_ff[31:16] == 16'h0001 |=> s2_ff.value ==
		$past(a_ff) - {{24{$past(b_ff[15])}}, $past(b_ff[15:0])})
		else $error("mac subtract wrong");
	a_add_res: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_ADD |=> s2_ff.value == 40'($past(a_ff) + $past(b_ff)))
		else $error("add result wrong");
	a_shl_res: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_SHL && s1_ff.shamt == 6'h01
		|=> s2_ff.value == {$past(a_ff[38:0]), 1'b0})
		else $error("left shift wrong");
	a_load_wr: assert property (@(posedge sys_clk) disable iff (!rstn)
		s2_ff.valid && s2_ff.fmask == 3'h7 |=> gr_ff[$past(s2_ff.dst)] == $past(s2_ff.value))
		else $error("full write not stored");
	a_mac_add: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_MAC && s1_ff.psh == FPA_PSH_NONE && !s1_ff.mac_sub
		&& b_ff[31:16] == 16'h0001 |=> s2_ff.value ==
		40'($past(a_ff) + {{24{$past(b_ff[15])}}, $past(b_ff[15:0])}))
		else $error("mac add wrong");
	a_psh_1: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_MAC && s1_ff.psh == FPA_PSH_1 && b_ff[15:0] == 16'h0000
		|=> s2_ff.value == 40'($signed($past(a_ff)) >>> 1))
		else $error("pre-shift by 1 wrong");
	a_sub_res: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_SUB |=> s2_ff.value == 40'($past(a_ff) - $past(b_ff)))
		else $error("subtract result wrong");
	a_and_res: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_AND |=> s2_ff.value == ($past(a_ff) & $past(b_ff)))
		else $error("and result wrong");
	a_or_res: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_OR |=> s2_ff.value == ($past(a_ff) | $past(b_ff)))
		else $error("or result wrong");
	a_xor_res: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_XOR |=> s2_ff.value == ($past(a_ff) ^ $past(b_ff)))
		else $error("xor result wrong");
	a_neg_res: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_NEG |=> s2_ff.value == 40'(40'h00_0000_0000 - $past(a_ff)))
		else $error("negate result wrong");
	a_nop_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
		s1v_ff && s1_ff.op == FPA_OP_NOP |=> !wb_valid)
		else $error("no-op produced a completion");

	// -------------------------------------------------------------
	// field protection
	// -------------------------------------------------------------
	a_low_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
		s2_ff.valid && !s2_ff.fmask[0] |=> gr_ff[$past(s2_ff.dst)][15:0] ==
		$past(gr_ff[s2_ff.dst][15:0]))
		else $error("low field changed on partial write");
	a_high_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
		s2_ff.valid && !s2_ff.fmask[1] |=> gr_ff[$past(s2_ff.dst)][31:16] ==
		$past(gr_ff[s2_ff.dst][31:16]))
		else $error("high field changed on partial write");
	// scenarios worth seeing at least once
	c_mac: cover property (@(posedge sys_clk) s1v_ff && s1_ff.op == FPA_OP_MAC);
	c_shra: cover property (@(posedge sys_clk) s1v_ff && s1_ff.op == FPA_OP_SHRA);
	c_part: cover property (@(posedge sys_clk) s2_ff.valid && s2_ff.fmask == 3'h2);
	c_b2b: cover property (@(posedge sys_clk) cmd_valid ##1 cmd_valid ##1 cmd_valid);
	c_psh16: cover property (@(posedge sys_clk) s1v_ff && s1_ff.psh == FPA_PSH_16);
endmodule

// *** sim/fpa_mem_model.sv ***
`timescale 1ns/1ps
// stands in for data memory: keeps whatever word a store pulls out
module fpa_mem_model
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// store request from the sequencer
	input  wire logic [2:0]  st_sel,
	// store read port of the datapath
	output logic      [2:0]  rd_sel,
	input  wire logic [39:0] rd_data,
	// last word written into memory
	output logic      [39:0] mem_ff
);
	assign rd_sel = st_sel;
	// memory write lands one edge after the port answers
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			mem_ff <= 40'h00_0000_0000;
		else
			mem_ff <= rd_data;
endmodule

// *** sim/tb_fixed_point_arith_unit.sv ***
`timescale 1ns/1ps
module tb_fixed_point_arith_unit;
	import fpa_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        sys_clk = 0, rstn = 0, cmd_valid = 0, wb_valid;
	fpa_cmd_t    cmd = '0;
	logic [2:0]  st_sel = 0, rd_sel;
	logic [39:0] rd_data, wb_value, mem_ff;
	int          num_errors = 0, checks_done = 0;
	// negative a and negative b high half exercise sign handling
	localparam logic [39:0] A = 40'h80_FFFF_5678, B = 40'h00_FFFD_0002;

	fpa_unit uut (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
		.rd_sel(rd_sel), .rd_data(rd_data), .wb_valid(wb_valid), .wb_value(wb_value));
	fpa_mem_model mem (.sys_clk(sys_clk), .rstn(rstn), .st_sel(st_sel), .rd_sel(rd_sel),
		.rd_data(rd_data), .mem_ff(mem_ff));

	initial forever #2.5 sys_clk = ~sys_clk;

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [39:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	// sources fixed at r1 and r2 keeps every call short
	function automatic fpa_cmd_t mk(fpa_op_t o, logic [2:0] d, m, logic [39:0] ld = 0,
		logic [5:0] sh = 0, logic s = 0, fpa_psh_t p = FPA_PSH_NONE);
		return '{o, 3'h1, 3'h2, d, m, s, p, sh, ld};
	endfunction
	// one op alone; result stands for one cycle after the edge that follows its issue
	task automatic go(input fpa_cmd_t c, input logic [39:0] e);
		@(posedge sys_clk) cmd_valid <= 1;
		cmd <= c;
		@(posedge sys_clk) cmd_valid <= 0;
		@(posedge sys_clk) #1;
		chk(wb_valid, 1);
		chk(wb_value, e);
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [2:0] r, input logic [39:0] e);
		@(posedge sys_clk) st_sel <= r;
		repeat (2) @(posedge sys_clk);
		#1 chk(mem_ff, e);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		for (int i = 0; i < 8; i++)
			rd(3'(i), 40'h00_0000_0000);
	endtask
	task automatic t_fields;
		go(mk(FPA_OP_LOAD, 3'h1, 3'h7, A), A);
		go(mk(FPA_OP_LOAD, 3'h2, 3'h7, B), B);
		go(mk(FPA_OP_LOAD, 3'h3, 3'h7, 40'h11_2222_3333), 40'h11_2222_3333);
		go(mk(FPA_OP_LOAD, 3'h3, 3'h2, 40'hFF_FFFF_FFFF), 40'hFF_FFFF_FFFF);
		rd(3, 40'h11_FFFF_3333);
		go(mk(FPA_OP_LOAD, 3'h3, 3'h5, 40'h00_0000_0000), 40'h00_0000_0000);
		rd(3, 40'h00_FFFF_0000);
	endtask
	task automatic t_alu;
		fpa_op_t ops[8] = '{FPA_OP_ADD, FPA_OP_SUB, FPA_OP_AND, FPA_OP_OR, FPA_OP_XOR,
			FPA_OP_NOT, FPA_OP_NEG, FPA_OP_PASS};
		logic [39:0] ex[8] = '{A + B, A - B, A & B, A | B, A ^ B, ~A, -A, A};
		foreach (ops[i])
			go(mk(ops[i], 3'h4, 3'h7), ex[i]);
		rd(4, A);
	endtask
	// every pre-shift with both add and subtract
	task automatic t_mac;
		logic [39:0] p, acc;
		p = 40'($signed(B[15:0])) * 40'($signed(B[31:16]));
		for (int k = 0; k < 6; k++)
		begin
			acc = (k / 2 == 0) ? A : 40'($signed(A) >>> ((k / 2 == 1) ? 1 : 16));
			go(mk(FPA_OP_MAC, 3'h5, 3'h7, 0, 0, k[0], fpa_psh_t'(k / 2)),
				k[0] ? acc - p : acc + p);
		end
	endtask
	// zero product isolates the pre-shift; unit high half shows product sign extension
	task automatic t_mac_unit;
		go(mk(FPA_OP_LOAD, 3'h2, 3'h7, 40'h00_0001_0000), 40'h00_0001_0000);
		go(mk(FPA_OP_MAC, 3'h5, 3'h7, 0, 0, 1, FPA_PSH_16), 40'($signed(A) >>> 16));
		go(mk(FPA_OP_MAC, 3'h5, 3'h7, 0, 0, 0, FPA_PSH_1), 40'($signed(A) >>> 1));
		go(mk(FPA_OP_LOAD, 3'h2, 3'h7, 40'h00_0001_8000), 40'h00_0001_8000);
		go(mk(FPA_OP_MAC, 3'h5, 3'h7, 0, 0, 1), A + 40'h00_0000_8000);
		go(mk(FPA_OP_MAC, 3'h5, 3'h7, 0, 0, 0), A - 40'h00_0000_8000);
	endtask
	// counts at and beyond the word width must give all fill
	task automatic t_shift;
		int sh[6] = '{0, 1, 16, 39, 40, 63};
		foreach (sh[i])
		begin
			go(mk(FPA_OP_SHL, 3'h6, 3'h7, 0, 6'(sh[i])), A << sh[i]);
			go(mk(FPA_OP_SHRA, 3'h6, 3'h7, 0, 6'(sh[i])), 40'($signed(A) >>> sh[i]));
			go(mk(FPA_OP_SHRL, 3'h6, 3'h7, 0, 6'(sh[i])), A >> sh[i]);
		end
	endtask
	// ops on consecutive edges, then a no-op that must stay silent
	task automatic t_b2b;
		@(posedge sys_clk) cmd_valid <= 1;
		cmd <= mk(FPA_OP_ADD, 3'h3, 3'h7);
		@(posedge sys_clk) cmd <= mk(FPA_OP_XOR, 3'h4, 3'h7);
		@(posedge sys_clk) cmd <= mk(FPA_OP_NOP, 3'h5, 3'h7);
		#1 chk(wb_value, A + B);
		chk(wb_valid, 1);
		@(posedge sys_clk) cmd_valid <= 0;
		#1 chk(wb_value, A ^ B);
		@(posedge sys_clk) #1 chk(wb_valid, 0);
		rd(3, A + B);
	endtask

	// ------------------------------------------------------------
	// sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic summarize;
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1;
		t_reset;
		t_fields;
		t_alu;
		t_mac;
		t_shift;
		t_b2b;
		t_mac_unit;
		summarize;
	end
	// the whole run needs well under a thousand cycles
	initial
	begin
		#20000;
		num_errors++;
		summarize;
	end
endmodule
